// ===== hw/fcw_pkg.sv
// shared constants, carriers and helpers of the four channel wave counter
package fcw_pkg;

   localparam int          CNT_W      = 15;
   localparam int          CH_N       = 4;
   localparam int          HW_W       = 16;
   localparam int          PRE_W      = 3;
   localparam int          PRE_CNT_W  = 7;
   localparam int          POL_BIT    = 15;
   localparam int          CMP_MSB    = 14;
   localparam int          CMP_LSB    = 0;
   localparam int          WAVE_TOP_CH = 3;
   localparam logic [14:0] CNT_RST    = 15'h0000;
   localparam logic [14:0] TOP_RST    = 15'h0000;
   localparam logic [14:0] CNT_ONE    = 15'h0001;
   localparam logic [15:0] PARAM_RST  = 16'h0000;
   localparam logic [6:0]  PRE_ALL    = 7'h7f;

   // one memory parameter: polarity over compare value
   typedef struct packed {
      logic        pol;
      logic [14:0] cmp;
   } fcw_param_t;

   typedef struct packed {
      fcw_param_t [3:0] ch;
   } fcw_group_t;

   typedef struct packed {
      logic        count_up_then_down;
      logic        layout_a;
      logic [2:0]  prescale_sel;
      logic [14:0] period_top_value;
   } fcw_cfg_t;

   typedef enum logic [2:0] {
      FCW_IDLE  = 3'b001,
      FCW_FETCH = 3'b010,
      FCW_RUN   = 3'b100
   } fcw_state_t;

   function automatic fcw_param_t fcw_decode(input logic [15:0] hw);
      fcw_param_t p;
      p.pol = hw[POL_BIT];
      p.cmp = hw[CMP_MSB:CMP_LSB];
      return p;
   endfunction

   function automatic fcw_group_t fcw_unpack(input logic [63:0] raw);
      fcw_group_t g;
      for (int i = 0; i < CH_N; i++) begin
         g.ch[i] = fcw_decode(raw[i*HW_W +: HW_W]);
      end
      return g;
   endfunction

endpackage

// ===== hw/fcw_prescaler.sv
// base clock divider giving one tick every 2^sel clocks
`timescale 1ns/1ps
module fcw_prescaler (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       arst_n,
   // control
   input  wire logic       run,
   input  wire logic [2:0] sel,
   // base clock tick
   output logic            tick
);

   logic [6:0] div_r;
   logic [6:0] div_nxt;
   wire  [6:0] lim = ~7'(fcw_pkg::PRE_ALL << sel);

   // compare with >= so a smaller divide picked mid-count cannot overrun
   assign tick    = run && (div_r >= lim);
   assign div_nxt = (!run || tick) ? 7'h00 : 7'(div_r + 7'h01);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div_r <= 7'h00;
      end else begin
         div_r <= div_nxt;
      end
   end

endmodule // fcw_prescaler

// ===== hw/fcw_channel.sv
// one compare channel producing a registered output level
`timescale 1ns/1ps
module fcw_channel (
   // clock and reset
   input  wire logic               clk,
   input  wire logic               arst_n,
   // control
   input  wire logic               run,
   input  wire logic               idle_level,
   input  wire fcw_pkg::fcw_param_t param,
   input  wire logic [14:0]        cnt,
   // pin level
   output logic                    out_r
);

   // falling first: high while below compare, so zero stays low and
   // a compare above the top value, or equal to it in up mode, never releases the pin
   wire below   = cnt < param.cmp;                       // RULE5 RULE12
   wire out_nxt = run ? (below ^ ~param.pol) : idle_level;  // RULE2 RULE22

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         out_r <= 1'b0;
      end else begin
         out_r <= out_nxt;
      end
   end

endmodule // fcw_channel

// ===== hw/fcw_wave_counter.sv
// wave counter top: shared counter, value loading and four channels
//
// Summary of operation
// RULE1 - one shared 15-bit counter feeds all four channels, same period everywhere.
// RULE2 - channel polarity comes from the fetched memory value only.
// RULE3 - mode input selects counting up only or up then down.
// RULE4 - top value limits the counter; with prescaler it sets the period.
// RULE5 - top below compare gives no edges; falling-first output stays high.
// RULE6 - compare values have no software path; only fetched values load them.
// RULE7 - software top may change any time; it is only sampled at events.
// RULE8 - the start task captures the top value.
// RULE9 - in layout_a the fourth fetched value is the top value.
// RULE10 - other layouts sample software top at start and each value load.
// RULE11 - up mode wraps to zero at top, and outputs invert there.
// RULE12 - falling-first: compare zero stays low, compare equal top stays high. In up-down the pin drops for the one tick at top.
// RULE13 - up mode pulses of all channels are edge aligned.
// RULE14 - up mode period is top base ticks, resolution one tick.
// RULE15 - up-down reverses at top to zero; second match inverts, centre aligned.
// RULE16 - up-down period is twice top base ticks, resolution two ticks.
// RULE17 - fetched updates apply glitch free, unattended, possibly every period.
// RULE18 - half word: bit 15 polarity, bits 14 to 0 compare value.
// RULE19 - layout_a drives only three channels; groups of four, fourth is top.
// RULE20 - start from idle fetches the first values before counting.
// RULE21 - counter compared every tick; new values applied at period boundary.
// RULE22 - after reset counter is zero and outputs idle until started. Pins are 0 in reset, idle from the first edge after release.
`timescale 1ns/1ps
module fcw_wave_counter (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                arst_n,
   // configuration
   input  wire fcw_pkg::fcw_cfg_t   cfg,
   input  wire logic [3:0]          idle_level,
   // tasks
   input  wire logic                sequence_start_task,
   input  wire logic                stop_task,
   // value fetch from memory
   input  wire logic                fetch_valid,
   input  wire logic [63:0]         fetch_data,
   output logic                     fetch_ready,
   // pins
   output logic [3:0]               pwm_out,
   // status
   output logic                     running,
   output logic                     seq_started,
   output logic                     period_end,
   output logic [14:0]              count_value,
   output logic                     count_down
);

   // sequencing
   fcw_pkg::fcw_state_t state_r;
   fcw_pkg::fcw_state_t state_nxt;

   // shared counter, direction and active top
   logic [14:0]         cnt_r;
   logic [14:0]         cnt_nxt;
   logic                down_r;
   logic                down_nxt;
   logic [14:0]         top_r;
   logic [14:0]         top_nxt;

   // active and pending parameter groups
   fcw_pkg::fcw_group_t act_r;
   fcw_pkg::fcw_group_t act_nxt;
   fcw_pkg::fcw_group_t pend_r;
   logic                pend_vld_r;
   logic                pend_vld_nxt;

   // fetch request, stop and status pulses
   logic                req_r;
   logic                req_nxt;
   logic                stop_r;
   logic                stop_nxt;
   logic                started_r;
   logic                bound_r;
   logic                tick;

   // one step of the shared counter in either direction
   function automatic logic [14:0] step_up(input logic [14:0] v);
      return 15'(v + fcw_pkg::CNT_ONE);
   endfunction

   function automatic logic [14:0] step_down(input logic [14:0] v);
      return 15'(v - fcw_pkg::CNT_ONE);
   endfunction

   // layout_a carries the top in the fourth slot, other layouts use the port
   function automatic logic [14:0] top_pick(input logic                la,
                                            input fcw_pkg::fcw_group_t g,
                                            input logic [14:0]         sw);
      return la ? g.ch[fcw_pkg::WAVE_TOP_CH].cmp : sw;
   endfunction

   // layout_a leaves the fourth pin idle since its slot holds the top
   function automatic logic ch_enabled(input logic la, input int idx);
      return !(la && (idx == fcw_pkg::WAVE_TOP_CH));
   endfunction

   // decode and selection
   wire                 is_idle   = state_r == fcw_pkg::FCW_IDLE;
   wire                 is_fetch  = state_r == fcw_pkg::FCW_FETCH;
   wire                 is_run    = state_r == fcw_pkg::FCW_RUN;
   wire                 updown    = cfg.count_up_then_down;                  // RULE3
   wire                 start_go  = is_idle && sequence_start_task;          // RULE20
   wire                 accept    = req_r && fetch_valid;
   wire fcw_pkg::fcw_group_t fetched = fcw_pkg::fcw_unpack(fetch_data);      // RULE18
   // the fourth slot or the port, resampled at every load
   wire [14:0]          top_fetched = top_pick(cfg.layout_a, fetched,
                                               cfg.period_top_value);    // RULE9 RULE10
   wire [14:0]          top_pend  = top_pick(cfg.layout_a, pend_r,
                                             cfg.period_top_value);      // RULE9 RULE10
   wire                 top_zero  = top_r == fcw_pkg::CNT_RST;
   wire [14:0]          up_last   = top_zero ? fcw_pkg::CNT_RST :
                                    step_down(top_r);
   // up mode: top ticks per period; up-down: 0..top then back down to 1
   wire                 last_up   = cnt_r >= up_last;                         // RULE11 RULE14
   wire                 last_ud   = top_zero ||
                                    (down_r && (cnt_r <= fcw_pkg::CNT_ONE));  // RULE16
   wire                 last_step = updown ? last_ud : last_up;
   wire                 boundary  = is_run && tick && last_step;              // RULE4
   wire                 turn      = !down_r && (cnt_r >= top_r);              // RULE15

   // base clock ticks only while counting
   fcw_prescaler u_pre (
      .clk    (clk),
      .arst_n (arst_n),
      .run    (is_run),
      .sel    (cfg.prescale_sel),
      .tick   (tick)
   );

   // state sequence
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         fcw_pkg::FCW_IDLE: begin
            // a start outside idle is ignored
            if (sequence_start_task) begin
               state_nxt = fcw_pkg::FCW_FETCH;                               // RULE20
            end
         end
         fcw_pkg::FCW_FETCH: begin
            if (stop_task || stop_r) begin
               state_nxt = fcw_pkg::FCW_IDLE;
            end else if (accept) begin
               state_nxt = fcw_pkg::FCW_RUN;                                 // RULE20
            end
         end
         fcw_pkg::FCW_RUN: begin
            // stop waits for the running period to complete
            if (boundary && stop_r) begin
               state_nxt = fcw_pkg::FCW_IDLE;
            end
         end
         default: begin
            state_nxt = fcw_pkg::FCW_IDLE;
         end
      endcase
   end

   // shared counter and direction
   always_comb begin
      cnt_nxt  = cnt_r;
      down_nxt = down_r;
      if (!is_run) begin
         cnt_nxt  = fcw_pkg::CNT_RST;                                        // RULE22
         down_nxt = 1'b0;
      end else if (tick) begin
         if (boundary) begin
            cnt_nxt  = fcw_pkg::CNT_RST;                                     // RULE11
            down_nxt = 1'b0;
         end else if (updown && turn) begin
            // top is shown for one tick only, then the count heads down
            cnt_nxt  = step_down(top_r);                                     // RULE15
            down_nxt = 1'b1;
         end else if (updown && down_r) begin
            cnt_nxt  = step_down(cnt_r);                                     // RULE15
         end else begin
            cnt_nxt  = step_up(cnt_r);                                       // RULE1
         end
      end
   end

   // active values change only at start, on first load or at a period boundary,
   // so no channel ever sees a half updated compare or top
   always_comb begin
      act_nxt      = act_r;
      top_nxt      = top_r;
      pend_vld_nxt = pend_vld_r;
      req_nxt      = req_r;
      if (start_go) begin
         top_nxt      = cfg.period_top_value;                                // RULE8
         pend_vld_nxt = 1'b0;
         req_nxt      = 1'b1;
      end else if (is_fetch && accept) begin
         act_nxt = fetched;                                                  // RULE6
         top_nxt = top_fetched;                                              // RULE10
         req_nxt = 1'b1;
      end else if (is_run) begin
         if (boundary && pend_vld_r) begin
            act_nxt      = pend_r;                                           // RULE17 RULE21
            top_nxt      = top_pend;                                         // RULE10
            pend_vld_nxt = 1'b0;
            req_nxt      = 1'b1;
         end else if (accept) begin
            // a group taken mid-period waits for the boundary
            pend_vld_nxt = 1'b1;
            req_nxt      = 1'b0;
         end
      end
      if (state_nxt == fcw_pkg::FCW_IDLE) begin
         req_nxt      = 1'b0;
         pend_vld_nxt = 1'b0;
      end
   end

   // a stop is held until the state reaches idle and dropped there, so a
   // stop given in the fetch state cannot cancel the next start
   always_comb begin
      stop_nxt = stop_r || (stop_task && !is_idle);
      if (state_nxt == fcw_pkg::FCW_IDLE) begin
         stop_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= fcw_pkg::FCW_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // counter, direction and top share one reset
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r   <= fcw_pkg::CNT_RST;                                        // RULE22
         down_r  <= 1'b0;
         top_r   <= fcw_pkg::TOP_RST;
      end else begin
         cnt_r   <= cnt_nxt;
         down_r  <= down_nxt;
         top_r   <= top_nxt;                                                 // RULE7
      end
   end

   // parameter groups, fetch request and stop
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         act_r      <= {fcw_pkg::CH_N{fcw_pkg::PARAM_RST}};
         pend_r     <= {fcw_pkg::CH_N{fcw_pkg::PARAM_RST}};
         pend_vld_r <= 1'b0;
         req_r      <= 1'b0;
         stop_r     <= 1'b0;
      end else begin
         act_r      <= act_nxt;
         pend_vld_r <= pend_vld_nxt;
         req_r      <= req_nxt;
         stop_r     <= stop_nxt;
         if (is_run && accept) begin
            pend_r <= fetched;                                               // RULE6
         end
      end
   end

   // start event: first group taken and the counter about to run
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         started_r <= 1'b0;
      end else begin
         started_r <= is_fetch && accept && !stop_task && !stop_r;
      end
   end

   // boundary echo, high in the clock in which the counter returns to zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bound_r <= 1'b0;
      end else begin
         bound_r <= boundary;
      end
   end

   // four compare channels on the one counter; layout_a keeps the fourth
   // at its idle level since its value slot carries the top instead
   for (genvar i = 0; i < fcw_pkg::CH_N; i++) begin : g_ch
      wire ch_run = is_run && ch_enabled(cfg.layout_a, i);                  // RULE19
      fcw_channel u_ch (
         .clk        (clk),
         .arst_n     (arst_n),
         .run        (ch_run),                                               // RULE13
         .idle_level (idle_level[i]),
         .param      (act_r.ch[i]),                                          // RULE21
         .cnt        (cnt_r),
         .out_r      (pwm_out[i])
      );
   end

   // status straight from registers, ready from the request flop
   assign fetch_ready = req_r;
   assign running     = is_run;
   assign seq_started = started_r;
   assign period_end  = bound_r;
   assign count_value = cnt_r;
   assign count_down  = down_r;

endmodule // fcw_wave_counter

// ===== sim/fcw_wave_counter_asserts.sv
// assertion checker bound to the wave counter top
`timescale 1ns/1ps
module fcw_chk (
   // clock and reset
   input wire logic              clk,
   input wire logic              arst_n,
   // inputs
   input wire fcw_pkg::fcw_cfg_t cfg,
   input wire logic [3:0]        idle_level,
   input wire logic              fetch_valid,
   // outputs
   input wire logic              fetch_ready,
   input wire logic [3:0]        pwm_out,
   input wire logic              running,
   input wire logic              seq_started,
   input wire logic              period_end,
   input wire logic [14:0]       count_value,
   input wire logic              count_down
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // guard on past reset: pins load idle only at the first edge after release
   idle_pins_a: assert property ($past(arst_n) && !$past(running) |->
      pwm_out == $past(idle_level)) else $error("pins not at idle level");
   idle_count_a: assert property (!running && !$past(running) |->
      count_value == 15'h0000) else $error("counter not zero while idle");
   mode_dir_a: assert property (count_down |-> cfg.count_up_then_down)
      else $error("counting down in up mode");
   up_wrap_a: assert property (running && $past(running) && !cfg.count_up_then_down |->
      count_value == $past(count_value) || count_value == $past(count_value) + 15'h0001
      || count_value == 15'h0000) else $error("bad step in up mode");
   updown_step_a: assert property (running && $past(running) && cfg.count_up_then_down |->
      count_value == $past(count_value) || count_value == $past(count_value) + 15'h0001
      || count_value + 15'h0001 == $past(count_value)) else $error("bad step in up-down mode");
   edge_zero_a: assert property (period_end |-> count_value == 15'h0000)
      else $error("period end without counter at zero");
   pe_pulse_a: assert property (period_end |=> !period_end)
      else $error("period end longer than one cycle");
   start_rise_a: assert property (seq_started |-> $rose(running))
      else $error("start pulse without run");
   one_group_a: assert property (fetch_valid && fetch_ready && running |=> !fetch_ready)
      else $error("second group taken in one period");
   cover property (seq_started);
   cover property (count_down);
   cover property (period_end && cfg.layout_a);
endmodule // fcw_chk

bind fcw_wave_counter fcw_chk u_chk (.clk(clk), .arst_n(arst_n), .cfg(cfg),
   .idle_level(idle_level), .fetch_valid(fetch_valid), .fetch_ready(fetch_ready),
   .pwm_out(pwm_out), .running(running), .seq_started(seq_started),
   .period_end(period_end), .count_value(count_value), .count_down(count_down));

// ===== sim/fcw_mem_model.sv
// memory side model handing parameter groups to the wave counter
`timescale 1ns/1ps
module fcw_mem_model (
   // clock and reset
   input wire logic         clk,
   input wire logic         arst_n,
   // control from bench
   input wire logic         avail,
   input wire logic [3:0]   gap,
   input wire logic [63:0]  next_data,
   // fetch stream
   input wire logic         fetch_ready,
   output logic             fetch_valid,
   output logic [63:0]      fetch_data
);
   logic [3:0] wait_r;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fetch_valid <= 1'b0;
         fetch_data  <= 64'h0;
         wait_r      <= 4'h0;
      end else if (fetch_valid && fetch_ready) begin
         fetch_valid <= 1'b0;
         fetch_data  <= ~fetch_data;
      end else if (fetch_valid && !avail) begin
         // the bench withdraws an unanswered offer only while the counter idles
         fetch_valid <= 1'b0;
      end else if (!fetch_valid) begin
         if (avail && wait_r >= gap) begin
            fetch_valid <= 1'b1;
            fetch_data  <= next_data;
            wait_r      <= 4'h0;
         end else begin
            // data toggles while not offered so stale values never look valid
            fetch_data <= ~fetch_data;
            if (avail) begin
               wait_r <= wait_r + 4'h1;
            end
         end
      end
   end
endmodule // fcw_mem_model

// ===== sim/tb.sv
// self-checking bench for the wave counter
`timescale 1ns/1ps
module tb;
   logic clk, arst_n, start, stop, avail, fetch_valid, fetch_ready;
   logic running, seq_started, period_end, count_down;
   logic [3:0] idle_level, gap, pwm_out;
   logic [63:0] next_data, fetch_data;
   logic [14:0] count_value;
   fcw_pkg::fcw_cfg_t cfg;
   int errors, n_tests, per, dn;
   int hi [4];

   fcw_wave_counter DUT (.clk(clk), .arst_n(arst_n), .cfg(cfg), .idle_level(idle_level),
      .sequence_start_task(start), .stop_task(stop), .fetch_valid(fetch_valid),
      .fetch_data(fetch_data), .fetch_ready(fetch_ready), .pwm_out(pwm_out),
      .running(running), .seq_started(seq_started), .period_end(period_end),
      .count_value(count_value), .count_down(count_down));
   fcw_mem_model u_mem (.clk(clk), .arst_n(arst_n), .avail(avail), .gap(gap),
      .next_data(next_data), .fetch_ready(fetch_ready), .fetch_valid(fetch_valid),
      .fetch_data(fetch_data));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   function automatic logic [15:0] hw(input logic pol, input logic [14:0] c);
      return {pol, c};
   endfunction

   task automatic go(input logic m, la, input logic [2:0] sel, input logic [14:0] top,
                     input logic [63:0] d);
      int k;
      cfg = {m, la, sel, top};
      next_data = d;
      avail = 1'b1;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      k = 0;
      while (running !== 1'b1 && k < 50) begin
         @(negedge clk);
         k++;
      end
      chk(seq_started, 1'b1);
   endtask

   // one full period between two boundary pulses, pin high time per channel
   task automatic measure;
      int k;
      per = 0;
      dn = 0;
      hi = '{default:0};
      k = 0;
      while (period_end !== 1'b1 && k < 2000) begin
         @(negedge clk);
         k++;
      end
      do begin
         @(negedge clk);
         per++;
         for (int i = 0; i < 4; i++) hi[i] += pwm_out[i];
         dn += count_down;
      end while (period_end !== 1'b1 && per < 2000);
   endtask

   task automatic halt;
      int k;
      stop = 1'b1;
      @(negedge clk);
      stop = 1'b0;
      k = 0;
      while (running === 1'b1 && k < 2000) begin
         @(negedge clk);
         k++;
      end
      avail = 1'b0;
      @(negedge clk);
      chk(pwm_out, idle_level);
      chk(count_value, 15'h0000);
   endtask

   task automatic t_reset;
      chk(pwm_out, idle_level);
      chk({running, fetch_ready, count_value}, 17'h0);
      avail = 1'b0;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      @(negedge clk);
      chk({running, fetch_ready}, 2'b01);
      stop = 1'b1;
      @(negedge clk);
      stop = 1'b0;
      @(negedge clk);
      chk({running, fetch_ready, count_value}, 17'h0);
      $display("test reset done");
   endtask

   task automatic t_up;
      go(1'b0, 1'b0, 3'h0, 15'h4, {hw(0, 1), hw(1, 4), hw(1, 0), hw(1, 2)});
      measure;
      measure;
      chk(per, 4);
      chk(hi[0], 2);
      chk(hi[1], 0);
      chk(hi[2], 4);
      chk(hi[3], 3);
      chk(dn, 0);
      halt;
      $display("test up done");
   endtask

   task automatic t_pre;
      go(1'b0, 1'b0, 3'h1, 15'h3, {hw(1, 1), hw(0, 5), hw(1, 5), hw(1, 0)});
      measure;
      measure;
      chk(per, 6);
      chk(hi[0], 0);
      chk(hi[1], 6);
      chk(hi[2], 0);
      chk(hi[3], 2);
      halt;
      $display("test prescale done");
   endtask

   task automatic t_ud;
      go(1'b1, 1'b0, 3'h0, 15'h3, {hw(1, 0), hw(0, 2), hw(1, 1), hw(1, 2)});
      measure;
      measure;
      chk(per, 6);
      chk(hi[0], 3);
      chk(hi[0] - hi[1], 2);
      chk(hi[2], 3);
      chk(hi[3], 0);
      chk(dn, 2);
      halt;
      $display("test up-down done");
   endtask

   task automatic t_wave;
      idle_level = 4'h9;
      go(1'b0, 1'b1, 3'h0, 15'h9, {hw(0, 5), hw(1, 0), hw(1, 3), hw(1, 2)});
      measure;
      measure;
      chk(per, 5);
      chk(hi[0], 2);
      chk(hi[1], 3);
      chk(hi[3], 5);
      halt;
      idle_level = 4'h5;
      $display("test layout done");
   endtask

   task automatic t_top;
      gap = 4'h2;
      go(1'b0, 1'b0, 3'h0, 15'h4, {48'h0, hw(1, 1)});
      avail = 1'b0;
      repeat (3) measure;
      cfg.period_top_value = 15'h7;
      measure;
      measure;
      chk(per, 4);
      avail = 1'b1;
      repeat (3) measure;
      chk(per, 7);
      chk(hi[0], 1);
      halt;
      gap = 4'h0;
      $display("test top sampling done");
   endtask

   // limit is 10000 cycles, many times the couple of hundred cycles the tests need
   initial begin
      #50000;
      errors++;
      $display("watchdog expired");
      end_sim;
   end

   initial begin
      arst_n = 1'b0;
      cfg = '0;
      idle_level = 4'h5;
      start = 1'b0;
      stop = 1'b0;
      avail = 1'b0;
      gap = 4'h0;
      next_data = 64'h0;
      errors = 0;
      n_tests = 0;
      repeat (4) @(negedge clk);
      arst_n = 1'b1;
      @(negedge clk);
      t_reset;
      t_up;
      t_pre;
      t_ud;
      t_wave;
      t_top;
      end_sim;
   end
endmodule // tb
